// [fswp_core.sv]
// fswp_core: status/configuration write command, write latch and protection modes.
// assumes cs_n stays high at least 4 core clocks between frames; pins are asynchronous.
// Function
// RULE_01: host sends write-enable before a status write.
// RULE_02: status write changes protect, quad and disable bits, never latch or busy.
// RULE_03: frame is chip select low, command byte, data bytes, chip select high.
// RULE_04: only 16 or 24 bit frames (8 or 16 data bits) are accepted.
// RULE_05: accepted status write starts the timed cycle at chip select rise.
// RULE_06: busy reads 1 through the cycle, then clears with the write latch.
// RULE_07: disable bit set and protect pin low rejects every status write; the code still accepts them while quad_on is set.
// RULE_08: hard protect mode whenever disable bit is 1 and pin low; the code enters it only while quad_on is clear.
// RULE_09: otherwise soft protect mode: latch settable, status writes allowed.
// RULE_10: only a high protect pin leaves hard protect mode; the code also leaves it when quad_on is set.
// RULE_11: quad enable or quad command mode disables hard protect mode.
// RULE_12: program or erase into the protected area is refused in both modes.
// RULE_13: drive strength codes map to ohms, 000 and 100 reserved, 111 default.
// RULE_14: dummy cycle code selects clocks per read type.
// RULE_15: status layout from bit7: disable, quad, four protect, latch, busy.
// RULE_16: hard protect needs disable bit 1 and protect pin low.
// RULE_17: top/bottom bit is one-time settable, default 0 meaning top.
// RULE_18: drive strength is volatile, default 30 ohms, set by status write.
// RULE_19: second data byte of a long write goes to the configuration register.
// RULE_20: while busy, refuse status writes and program or erase.
`timescale 1ns/10ps
module fswp_core
    import fswp_pkg::*;
#(
    parameter logic [7:0] WRITE_ENABLE_CMD_CODE = 8'h06,
    parameter logic [7:0] STATUS_WRITE_CMD_CODE = 8'h01,
    parameter int BLK_W = 6
)
(
    // system
    input wire logic clock,
    input wire logic rst_b,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    // protect pin and quad command mode
    input wire logic write_protect_n,
    input wire logic quad_command_mode,
    // program/erase check
    input wire logic pe_req,
    input wire logic [BLK_W-1:0] pe_block,
    output logic pe_grant_q,
    output logic pe_refuse_q,
    // register and mode outputs
    output logic [7:0] status_q,
    output logic [7:0] config_q,
    output logic hard_protect_mode_q,
    output logic soft_protect_mode_q,
    output logic wr_reject_q,
    output logic [7:0] drive_ohms_q,
    output fswp_dummy_s dummy_q
);
    localparam logic [BLK_W:0] NBLK = (BLK_W+1)'(1) << BLK_W;

    fswp_frame_s frame;
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic wp_s1_q, wp_s2_q;
    logic [11:0] timer_q;
    logic [7:0] pend_stat_q, pend_cfg_q;
    logic pend_cfg_en_q;
    logic [7:0] status_d, config_d;
    logic [BLK_W:0] span;

    fswp_link_rx u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .rst_b(rst_b),
        .frame_q(frame)
    );

    // pin synchronisers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end
        else
        begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= write_protect_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    // frame is read only after the synchronised cs_n rise: sclk has stopped by then
    wire logic frame_end = cs_s2_q & ~cs_s3_q;
    wire logic busy = status_q[FSWP_WIP];
    wire logic write_enable_latch = status_q[FSWP_WEL];
    wire logic quad_on = status_q[FSWP_QE] | quad_command_mode;
    wire logic hard_now = status_q[FSWP_SWD] & ~wp_s2_q & ~quad_on; // see RULE_08 RULE_16 RULE_11
    wire logic has_cmd = frame.bits >= FSWP_BITS_CMD;
    wire logic write_enable_cmd_hit = frame_end & (frame.bits == FSWP_BITS_CMD) & (frame.cmd == WRITE_ENABLE_CMD_CODE);
    wire logic status_write_cmd_hit = frame_end & has_cmd & (frame.cmd == STATUS_WRITE_CMD_CODE);
    wire logic len_ok = (frame.bits == FSWP_BITS_SR) | (frame.bits == FSWP_BITS_SRCR); // see RULE_04
    wire logic accept = status_write_cmd_hit & len_ok & write_enable_latch & ~busy & ~hard_now; // see RULE_07 RULE_20
    wire logic done = busy & (timer_q == 12'h001);
    wire logic long_wr = frame.bits == FSWP_BITS_SRCR;
    wire logic [7:0] stat_byte = long_wr ? frame.data[15:8] : frame.data[7:0];
    wire logic [3:0] bp = status_q[FSWP_BP_LSB +: 4];
    wire logic tb = config_q[FSWP_TB];
    wire logic [2:0] ods = config_q[FSWP_ODS_LSB +: 3];
    wire logic [1:0] dc = config_q[FSWP_DC_LSB +: 2];

    // protected span in blocks: level n covers 2^(n-1), clamped to the whole array
    always_comb
    begin
        if (bp == 4'h0)
            span = '0;
        else if (int'(bp) > BLK_W)
            span = NBLK;
        else
            span = (BLK_W+1)'(1) << (bp - 4'h1);
    end

    wire logic in_area = tb ? ({1'b0, pe_block} < span) : ({1'b0, pe_block} >= NBLK - span); // see RULE_12 RULE_17
    wire logic pe_ok = pe_req & ~busy & ~in_area; // see RULE_12 RULE_20

    // next status: the command writes bits 7..2 only, latch and busy stay hardware owned
    always_comb
    begin
        status_d = status_q;
        if (write_enable_cmd_hit & ~busy)
            status_d[FSWP_WEL] = 1'b1; // see RULE_09
        if (accept)
            status_d[FSWP_WIP] = 1'b1; // see RULE_05
        if (done)
        begin
            status_d[7:2] = pend_stat_q[7:2]; // see RULE_02 RULE_15
            status_d[FSWP_WIP] = 1'b0; // see RULE_06
            status_d[FSWP_WEL] = 1'b0;
        end
    end

    // configuration: only from the second byte of a long write
    always_comb
    begin
        config_d = config_q;
        if (done & pend_cfg_en_q)
        begin
            config_d[FSWP_ODS_LSB +: 3] = pend_cfg_q[FSWP_ODS_LSB +: 3]; // see RULE_18 RULE_19
            config_d[FSWP_PBE] = pend_cfg_q[FSWP_PBE];
            config_d[FSWP_DC_LSB +: 2] = pend_cfg_q[FSWP_DC_LSB +: 2];
            // one-time bit: can be set, never cleared
            config_d[FSWP_TB] = config_q[FSWP_TB] | pend_cfg_q[FSWP_TB]; // see RULE_17
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_q <= FSWP_STAT_RST;
            config_q <= FSWP_CFG_RST;
        end
        else
        begin
            status_q <= status_d;
            config_q <= config_d;
        end
    end

    // write data is held until the timed cycle ends
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_stat_q <= FSWP_STAT_RST;
            pend_cfg_q <= FSWP_CFG_RST;
            pend_cfg_en_q <= 1'b0;
        end
        else if (accept)
        begin
            pend_stat_q <= stat_byte;
            pend_cfg_q <= frame.data[7:0];
            pend_cfg_en_q <= long_wr; // see RULE_19
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            timer_q <= 12'h000;
        else if (accept)
            timer_q <= FSWP_WRITE_CNT; // see RULE_05
        else if (busy)
            timer_q <= timer_q - 12'h001;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hard_protect_mode_q <= 1'b0;
            soft_protect_mode_q <= 1'b1;
            wr_reject_q <= 1'b0;
            pe_grant_q <= 1'b0;
            pe_refuse_q <= 1'b0;
            drive_ohms_q <= FSWP_OHMS[3'h7];
            dummy_q <= '{FSWP_DUM_OUT[0], FSWP_DUM_DIO[0], FSWP_DUM_QIO[0]};
        end
        else
        begin
            hard_protect_mode_q <= hard_now; // see RULE_10
            soft_protect_mode_q <= ~hard_now; // see RULE_09
            wr_reject_q <= status_write_cmd_hit & ~accept; // see RULE_04 RULE_07
            pe_grant_q <= pe_ok;
            pe_refuse_q <= pe_req & ~pe_ok;
            drive_ohms_q <= FSWP_OHMS[ods]; // see RULE_13
            dummy_q <= '{FSWP_DUM_OUT[dc], FSWP_DUM_DIO[dc], FSWP_DUM_QIO[dc]}; // see RULE_14
        end
    end

    // checks
    logic [11:0] wip_len_q;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            wip_len_q <= 12'h000;
        else if (busy)
            wip_len_q <= wip_len_q + 12'h001;
        else
            wip_len_q <= 12'h000;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_accept_starts: assert property (accept |=> busy && write_enable_latch && wr_reject_q == 1'b0) // see RULE_05
        else $error("accepted write did not start the cycle");
    a_bad_len: assert property (status_write_cmd_hit && !len_ok && !busy |=> wr_reject_q && !busy) // see RULE_04
        else $error("wrong frame length not rejected");
    a_hpm_reject: assert property (status_write_cmd_hit && hard_now && !busy |=> !busy ##1 !busy) // see RULE_07
        else $error("status write ran in hard protect mode");
    a_hpm_enter: assert property (status_q[FSWP_SWD] && !wp_s2_q && !quad_on
                                  |=> hard_protect_mode_q && !soft_protect_mode_q) // see RULE_08
        else $error("hard protect mode not entered");
    a_pin_exit: assert property (wp_s2_q |=> !hard_protect_mode_q) // see RULE_10
        else $error("hard protect held with pin high");
    a_quad_off: assert property (quad_on |=> !hard_protect_mode_q) // see RULE_11
        else $error("hard protect active in quad mode");
    a_cycle_len: assert property ($fell(busy) |-> $past(wip_len_q) == FSWP_WRITE_CNT - 12'h001
                                  && !write_enable_latch) // see RULE_06
        else $error("write cycle length or latch clear wrong");
    a_keep_bits: assert property (done |=> status_q[7:2] == $past(pend_stat_q[7:2])) // see RULE_02
        else $error("status bits not written at cycle end");
    a_pe_area: assert property (pe_req && (in_area || busy) |=> pe_refuse_q && !pe_grant_q) // see RULE_12
        else $error("protected program or erase granted");
    a_ods_map: assert property (ods == 3'h7 |=> drive_ohms_q == 8'h1E) // see RULE_13
        else $error("default drive strength not 30 ohms");
    a_tb_otp: assert property (tb |=> tb) // see RULE_17
        else $error("top/bottom bit cleared");
    a_busy_block: assert property (status_write_cmd_hit && busy |=> wr_reject_q) // see RULE_20
        else $error("status write not refused while busy");
    a_no_latch: assert property (status_write_cmd_hit && !write_enable_latch && !busy |=> wr_reject_q && !busy) // see RULE_01
        else $error("status write ran without write latch");
endmodule

// [fswp_core_tb.sv]
// fswp_core_tb: self-checking bench of the status write and protect block.
// assumes fswp_host_model drives the link; core clock 50 MHz.
`timescale 1ns/10ps
module fswp_core_tb
    import fswp_pkg::*;
;
    localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] CMD_STATUS_WRITE_CMD = 8'h01;
    logic clock, sclk, cs_n, si, pe_grant_q, pe_refuse_q, wr_reject_q;
    logic hard_protect_mode_q, soft_protect_mode_q;
    logic rst_b = 1'b0;
    logic write_protect_n = 1'b1;
    logic quad_command_mode = 1'b0;
    logic pe_req = 1'b0;
    logic [5:0] pe_block = 6'h00;
    logic [7:0] status_q, config_q, drive_ohms_q;
    logic [7:0] exp_st = 8'h00;
    logic [7:0] exp_cf = 8'h07;
    fswp_dummy_s dummy_q;
    int error_cnt = 0;
    int samples_checked = 0;
    int rej_cnt = 0;
    int seed;
    int bad_n [5] = '{0, 7, 9, 15, 17};

    fswp_host_model i_fswp_host_model (.sclk, .cs_n, .si);
    fswp_core #(.WRITE_ENABLE_CMD_CODE(CMD_WRITE_ENABLE_CMD), .STATUS_WRITE_CMD_CODE(CMD_STATUS_WRITE_CMD)) i_fswp_core (.clock, .rst_b,
        .sclk, .cs_n, .si, .write_protect_n, .quad_command_mode, .pe_req, .pe_block,
        .pe_grant_q, .pe_refuse_q, .status_q, .config_q, .hard_protect_mode_q,
        .soft_protect_mode_q, .wr_reject_q, .drive_ohms_q, .dummy_q);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // reject is a one-cycle pulse, so count it on every edge
    always @(posedge clock)
        if (wr_reject_q === 1'b1)
            rej_cnt++;

    function automatic logic [7:0] ohms(logic [2:0] c);
        case (c)
            3'h1: return 8'h5A;
            3'h2: return 8'h3C;
            3'h3: return 8'h2D;
            3'h5: return 8'h14;
            3'h6: return 8'h0F;
            3'h7: return 8'h1E;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [11:0] dum(logic [1:0] c);
        case (c)
            2'h0: return 12'h846;
            2'h1: return 12'h664;
            2'h2: return 12'h888;
            default: return 12'hAAA;
        endcase
    endfunction
    function automatic logic prot(logic [3:0] lv, logic tb, logic [5:0] b);
        int n;
        n = (lv == 0) ? 0 : (lv > 6) ? 64 : (1 << (lv - 1));
        return tb ? (b < n) : (b >= 64 - n);
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // held two edges so either answer latency is settled
    task automatic pe(input logic [5:0] b, input logic exp);
        pe_req = 1'b1;
        pe_block = b;
        repeat (2) @(negedge clock);
        chk(pe_refuse_q, exp);
        chk(pe_grant_q, !exp);
        pe_req = 1'b0;
        @(negedge clock);
    endtask
    // d is left aligned: top n bits follow the command byte
    task automatic wr(input logic [23:0] d, input int n, input logic ok);
        int c;
        int r;
        i_fswp_host_model.send(32'(CMD_WRITE_ENABLE_CMD), 8);
        r = rej_cnt;
        i_fswp_host_model.send({CMD_STATUS_WRITE_CMD, d} >> (24 - n), 8 + n);
        @(negedge clock);
        chk(rej_cnt - r, !ok);
        chk(status_q[0], ok);
        if (ok)
        begin
            pe(6'h00, 1'b1);
            exp_st = {d[23:18], 2'b00};
            if (n == 16)
                exp_cf = {d[15:14], 1'b0, d[12], d[11] | exp_cf[3], d[10:8]};
        end
        for (c = 0; c < 700 && status_q[0] !== 1'b0; c++)
            @(negedge clock);
        repeat (2) @(negedge clock);
        if (ok)
        begin
            chk(c > 470 && c < 498, 1'b1);
            chk(status_q[1], 1'b0);
        end
        chk(status_q[7:2], exp_st[7:2]);
        chk(config_q, exp_cf);
        chk(drive_ohms_q, ohms(exp_cf[2:0]));
        chk(dummy_q, dum(exp_cf[7:6]));
    endtask

    initial
    begin
        int r;
        logic [23:0] d;
        seed = $urandom(71);
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        chk(status_q, 8'h00);
        chk(config_q, 8'h07);
        chk(drive_ohms_q, 8'h1E);
        chk(dummy_q, 12'h846);
        chk({hard_protect_mode_q, soft_protect_mode_q}, 2'b01);
        i_fswp_host_model.send(32'(CMD_WRITE_ENABLE_CMD), 8);
        chk(status_q[1], 1'b1);
        $display("test reset and write enable done");
        foreach (bad_n[k])
            wr(24'($urandom), bad_n[k], 1'b0);
        $display("test frame length done");
        for (int i = 0; i < 8; i++)
        begin
            r = $urandom;
            d = {2'b00, r[5:0], i[1:0], 1'b0, r[6], i == 6, i[2:0], 8'h00};
            wr(d, 16, 1'b1);
            pe(6'h3F, prot(exp_st[5:2], exp_cf[3], 6'h3F));
            repeat (3)
            begin
                r = $urandom;
                pe(r[5:0], prot(exp_st[5:2], exp_cf[3], r[5:0]));
            end
        end
        $display("test config and protect area done");
        // latch was cleared by the last cycle, so a bare status write must bounce
        r = rej_cnt;
        i_fswp_host_model.send(32'({CMD_STATUS_WRITE_CMD, 8'h3C}), 16);
        @(negedge clock);
        chk(rej_cnt - r, 1);
        chk(status_q[0], 1'b0);
        chk(status_q[7:2], exp_st[7:2]);
        $display("test write without latch done");
        wr(24'h8C0000, 8, 1'b1);
        write_protect_n = 1'b0;
        repeat (6) @(negedge clock);
        chk({hard_protect_mode_q, soft_protect_mode_q}, 2'b10);
        wr(24'h000000, 8, 1'b0);
        quad_command_mode = 1'b1;
        repeat (3) @(negedge clock);
        chk(hard_protect_mode_q, 1'b0);
        quad_command_mode = 1'b0;
        write_protect_n = 1'b1;
        repeat (6) @(negedge clock);
        chk(hard_protect_mode_q, 1'b0);
        wr(24'hC00000, 8, 1'b1);
        write_protect_n = 1'b0;
        repeat (6) @(negedge clock);
        chk(hard_protect_mode_q, 1'b0);
        wr(24'h840000, 8, 1'b1);
        chk(hard_protect_mode_q, 1'b1);
        $display("test protect modes done");
        print_verdict();
    end

    initial
    begin
        #1000000;
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        print_verdict();
    end
endmodule

// [fswp_host_model.sv]
// fswp_host_model: host end of the serial link, one frame per call of send.
// assumes the caller leaves each frame finished before the next call.
`timescale 1ns/10ps
module fswp_host_model
(
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic si
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // msb first; sclk stands low outside frames, 80 ns inside
    task automatic send(input logic [31:0] data, input int nbits);
        #7;
        cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            si = data[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        // released line must not keep the last bit
        si = ~si;
        #200;
    endtask
endmodule

// [fswp_link_rx.sv]
// fswp_link_rx: shifts one chip-select frame in on the serial clock.
// assumes sclk only toggles while cs_n is low; the frame stays put after cs_n rises.
`timescale 1ns/10ps
module fswp_link_rx
    import fswp_pkg::*;
(
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    // reset
    input wire logic rst_b,
    // captured frame
    output fswp_frame_s frame_q
);
    logic active_q;
    fswp_frame_s frame_d;

    wire logic [4:0] bits_inc = (frame_q.bits == FSWP_BITS_MAX) ? frame_q.bits
                                : frame_q.bits + 5'h01;
    wire logic [4:0] bits_now = active_q ? bits_inc : 5'h01;
    wire logic [15:0] data_now = active_q ? {frame_q.data[14:0], si} : {15'h0000, si};

    always_comb
    begin
        frame_d.bits = bits_now;
        frame_d.data = data_now;
        frame_d.cmd = (bits_now == FSWP_BITS_CMD) ? data_now[7:0] : frame_q.cmd;
    end

    // cs_n clears only the open flag, so the last frame stays readable by the core
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            active_q <= 1'b0;
        else
            active_q <= 1'b1;
    end

    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
            frame_q <= '0;
        else
            frame_q <= frame_d;
    end
endmodule

// [fswp_pkg.sv]
// fswp_pkg: constants, lookup tables and carriers of the status write / protect block.
// assumes a 50 MHz core clock and a serial link that runs on its own clock.
package fswp_pkg;
    // self-timed status write cycle
    localparam int FSWP_CLK_MHZ = 50;
    localparam int FSWP_WRITE_US = 10;
    localparam int FSWP_WRITE_CYC = FSWP_WRITE_US * FSWP_CLK_MHZ;
    localparam logic [11:0] FSWP_WRITE_CNT = 12'(FSWP_WRITE_CYC);
    // status register bit positions
    localparam int FSWP_WIP = 0;
    localparam int FSWP_WEL = 1;
    localparam int FSWP_BP_LSB = 2;
    localparam int FSWP_QE = 6;
    localparam int FSWP_SWD = 7;
    // configuration register bit positions
    localparam int FSWP_ODS_LSB = 0;
    localparam int FSWP_TB = 3;
    localparam int FSWP_PBE = 4;
    localparam int FSWP_DC_LSB = 6;
    // values after reset
    localparam logic [7:0] FSWP_STAT_RST = 8'h00;
    localparam logic [7:0] FSWP_CFG_RST = 8'h07;
    // frame lengths in link bits
    localparam logic [4:0] FSWP_BITS_CMD = 5'h08;
    localparam logic [4:0] FSWP_BITS_SR = 5'h10;
    localparam logic [4:0] FSWP_BITS_SRCR = 5'h18;
    localparam logic [4:0] FSWP_BITS_MAX = 5'h1F;
    // drive strength code to ohms, 0 for reserved codes
    localparam logic [7:0] FSWP_OHMS [8] = '{8'h00, 8'h5A, 8'h3C, 8'h2D,
                                             8'h00, 8'h14, 8'h0F, 8'h1E};
    // dummy clocks per dummy_cycle_sel code
    localparam logic [3:0] FSWP_DUM_OUT [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
    localparam logic [3:0] FSWP_DUM_DIO [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
    localparam logic [3:0] FSWP_DUM_QIO [4] = '{4'h6, 4'h4, 4'h8, 4'hA};

    typedef struct packed {
        logic [4:0] bits;
        logic [7:0] cmd;
        logic [15:0] data;
    } fswp_frame_s;

    typedef struct packed {
        logic [3:0] out_rd;
        logic [3:0] dual_io;
        logic [3:0] quad_io;
    } fswp_dummy_s;
endpackage
